/* rtl/sensor_port_regs.vh */
`ifndef SENSOR_PORT_REGS_VH
`define SENSOR_PORT_REGS_VH
// ****************************************
// bus address and register map
// ****************************************
`define SLAVE_ADDR 7'h40
`define OFS_STATUS 8'h00
`define OFS_RES_HI 8'h01
`define OFS_RES_LO 8'h02
`define OFS_CONTROL 8'h03
`define OFS_PART 8'h11
`define FW_CMD_FIRST 8'h84
`define FW_CMD_SECOND 8'hb8
// ****************************************
// reset values and field positions
// ****************************************
`define STATUS_RESET 8'h01
`define CONTROL_RESET 8'h00
`define CTL_START 0
`define CTL_WARM 1
`define CTL_TEMP 4
`define CTL_FAST 5
`define CTL_WMASK 8'h33
// ****************************************
// conversion timing
// ****************************************
`define CLOCK_HZ 40000000
`define CONV_NORMAL_US 5800
`define CONV_FAST_US 2600
`define CONV_NORMAL_CYC (`CONV_NORMAL_US * (`CLOCK_HZ / 1000000))
`define CONV_FAST_CYC (`CONV_FAST_US * (`CLOCK_HZ / 1000000))
`endif

/* rtl/sensor_i2c_register_port.v */
// Notes on behaviour
// (R01) transactions start with start condition, address 0x40; only that address answers
// (R02) device acks address and every received byte in ninth clock
// (R03) reads need a pointer write, then repeated start with read bit
// (R04) single register read ends with master not-ack and stop
// (R05) after master ack of first result byte, device sends second byte
// (R06) master ends two-byte result read with not-ack and stop
// (R07) firmware revision read uses command bytes 0x84 then 0xb8
// (R08) firmware revision byte: major in bits 7:4, minor in 3:0
// (R09) master writes only defined register addresses
// (R10) reserved bits written zero; read value undefined (here zero)
// (R11) status bit 0 is 1 while converting, 0 when done; resets 1
// (R12) result high and low bytes hold latest result; reset zero
// (R13) control bit 5 picks fast or normal conversion time
// (R14) control bit 4 picks temperature over humidity
// (R15) control bit 0 starts conversion, bit 1 turns warming element on
// (R16) part code register at 0x11 read as single register
// (R17) master writes 0x01 or 0x11 to control to start conversions
// (R18) data byte after pointer is stored into the pointed register; here only the control register at 0x03 stores it, other writes are dropped
// (R19) master polls ready flag low before reading results
// (R20) chip select high keeps port idle and ignores bus traffic
// (R21) pointer advances after each sent byte
`timescale 1ns/1ps
`default_nettype none
`include "sensor_port_regs.vh"
module sensor_i2c_register_port #(
  parameter NORMAL_CYCLES = `CONV_NORMAL_CYC,
  parameter FAST_CYCLES = `CONV_FAST_CYC,
  parameter [7:0] PART_CODE = 8'ha0, // arbitrary value
  parameter [3:0] FW_MAJOR = 4'h3, // arbitrary value
  parameter [3:0] FW_MINOR = 4'h1 // arbitrary value
) (
  // clock and reset
  input wire clock,
  input wire nrst,
  // serial pins
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  input wire chip_select_low,
  // measurement side
  input wire [15:0] sample_value,
  output wire warming_element_on,
  output wire measure_temp,
  output wire converting
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  reg [1:0] scl_sync_reg, sda_sync_reg, cs_sync_reg;
  reg scl_last_reg, sda_last_reg;
  // two flops each; only the second stage is read
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      cs_sync_reg <= 2'h3;
      scl_last_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_in};
      sda_sync_reg <= {sda_sync_reg[0], sda_in};
      cs_sync_reg <= {cs_sync_reg[0], chip_select_low};
      scl_last_reg <= scl_sync_reg[1];
      sda_last_reg <= sda_sync_reg[1];
    end
  end
  wire scl = scl_sync_reg[1];
  wire sda = sda_sync_reg[1];
  wire deselected = cs_sync_reg[1];
  wire scl_rise = scl & ~scl_last_reg;
  wire scl_fall = ~scl & scl_last_reg;
  wire start_seen = scl & scl_last_reg & sda_last_reg & ~sda; // (R01)
  wire stop_seen = scl & scl_last_reg & ~sda_last_reg & sda;
  // ****************************************
  // protocol state machine
  // ****************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK = 3'h2;
  localparam ST_RECV = 3'h3;
  localparam ST_SEND = 3'h4;
  localparam ST_MACK = 3'h5;
  reg [2:0] state_reg;
  reg [2:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [7:0] pointer_reg;
  reg [1:0] wbyte_reg; // bytes received since address
  reg reading_reg, fw_armed_reg, fw_sel_reg, drive_low_reg;
  reg [7:0] control_reg;
  reg [7:0] res_hi_reg, res_lo_reg;
  reg busy_reg, ack_pend_reg;
  reg [23:0] conv_cnt_reg;
  reg start_pulse_reg;
  // read data mux; reserved bits read zero
  reg [7:0] rd_data;
  always @* begin
    rd_data = 8'h00;
    if (fw_sel_reg) begin
      rd_data = {FW_MAJOR, FW_MINOR}; // (R08)
    end else begin
      case (pointer_reg)
        `OFS_STATUS: rd_data = {7'h00, busy_reg}; // (R11)
        `OFS_RES_HI: rd_data = res_hi_reg; // (R12)
        `OFS_RES_LO: rd_data = res_lo_reg; // (R12)
        `OFS_CONTROL: rd_data = control_reg & `CTL_WMASK; // (R10)
        `OFS_PART: rd_data = PART_CODE; // (R16)
        default: rd_data = 8'h00;
      endcase
    end
  end
  // bus engine: acts on scl edges, reset by start/stop or deselect
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 3'h0;
      shift_reg <= 8'h00;
      pointer_reg <= 8'h00;
      wbyte_reg <= 2'h0;
      reading_reg <= 1'b0;
      fw_armed_reg <= 1'b0;
      fw_sel_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      control_reg <= `CONTROL_RESET;
      start_pulse_reg <= 1'b0;
      ack_pend_reg <= 1'b0;
    end else begin
      start_pulse_reg <= 1'b0;
      if (deselected) begin
        state_reg <= ST_IDLE; // (R20)
        drive_low_reg <= 1'b0;
      end else if (start_seen) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 3'h0;
        wbyte_reg <= 2'h0;
        drive_low_reg <= 1'b0;
      end else if (stop_seen) begin
        state_reg <= ST_IDLE;
        drive_low_reg <= 1'b0;
        fw_armed_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_RECV: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              ack_pend_reg <= (bit_cnt_reg == 3'h7);
            end else if (scl_fall && ack_pend_reg) begin
              ack_pend_reg <= 1'b0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == `SLAVE_ADDR) begin // (R01)
                  reading_reg <= shift_reg[0];
                  fw_sel_reg <= shift_reg[0] & fw_armed_reg; // (R07)
                  drive_low_reg <= 1'b1; // (R02)
                  state_reg <= ST_ACK;
                end else begin
                  state_reg <= ST_IDLE;
                end
              end else begin
                drive_low_reg <= 1'b1; // (R02)
                state_reg <= ST_ACK;
                if (wbyte_reg == 2'h0) begin
                  pointer_reg <= shift_reg;
                  fw_armed_reg <= (shift_reg == `FW_CMD_FIRST);
                end else if (fw_armed_reg && wbyte_reg == 2'h1 &&
                             shift_reg == `FW_CMD_SECOND) begin
                  fw_armed_reg <= 1'b1; // (R07)
                end else begin
                  fw_armed_reg <= 1'b0;
                  if (pointer_reg == `OFS_CONTROL) begin // (R18)
                    control_reg <= shift_reg & `CTL_WMASK; // (R15)
                    start_pulse_reg <= shift_reg[`CTL_START];
                  end
                end
                if (wbyte_reg != 2'h3) begin
                  wbyte_reg <= wbyte_reg + 2'h1;
                end
              end
            end
          end
          ST_ACK: begin
            // release ack at end of ninth clock, then load next byte
            if (scl_fall) begin
              bit_cnt_reg <= 3'h0;
              if (reading_reg) begin
                shift_reg <= rd_data;
                drive_low_reg <= ~rd_data[7];
                state_reg <= ST_SEND;
              end else begin
                drive_low_reg <= 1'b0;
                state_reg <= ST_RECV;
              end
            end
          end
          ST_SEND: begin
            if (scl_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7) begin
                drive_low_reg <= 1'b0;
                pointer_reg <= pointer_reg + 8'h01; // (R21)
                state_reg <= ST_MACK;
              end else begin
                shift_reg <= {shift_reg[6:0], 1'b0};
                drive_low_reg <= ~shift_reg[6];
              end
            end
          end
          ST_MACK: begin
            // master ack continues the read, not-ack ends it
            if (scl_rise) begin
              state_reg <= sda ? ST_IDLE : ST_ACK; // (R05)
              fw_sel_reg <= 1'b0;
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = drive_low_reg & ~deselected;
  // ****************************************
  // conversion timer
  // ****************************************
  // a new start restarts the timer; results latched at completion
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      busy_reg <= 1'b1; // (R11)
      conv_cnt_reg <= 24'h000000;
      res_hi_reg <= 8'h00;
      res_lo_reg <= 8'h00;
    end else if (start_pulse_reg) begin
      busy_reg <= 1'b1;
      conv_cnt_reg <= control_reg[`CTL_FAST] ? FAST_CYCLES[23:0] :
                      NORMAL_CYCLES[23:0]; // (R13)
    end else if (busy_reg && conv_cnt_reg != 24'h000000) begin
      conv_cnt_reg <= conv_cnt_reg - 24'h000001;
      if (conv_cnt_reg == 24'h000001) begin
        busy_reg <= 1'b0; // (R11)
        res_hi_reg <= sample_value[15:8]; // (R12)
        res_lo_reg <= sample_value[7:0];
      end
    end
  end
  assign converting = busy_reg;
  assign measure_temp = control_reg[`CTL_TEMP]; // (R14)
  assign warming_element_on = control_reg[`CTL_WARM]; // (R15)
endmodule
`default_nettype wire

/* verif/sensor_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_port_chk #(
  parameter int FAST_CYCLES = 20
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // serial pins
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic chip_select_low,
  // measurement side
  input wire logic warming_element_on,
  input wire logic measure_temp,
  input wire logic converting
);
  int run_len;
  // length of the current busy run, zero when idle
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_len <= 0;
    end else begin
      run_len <= converting ? run_len + 1 : 0;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // ****************************************
  // bus and conversion properties
  // ****************************************
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data pin driven high");
  // select needs two clocks through its synchroniser before the drive must be off
  property p_quiet;
    chip_select_low && $past(chip_select_low) && $past(chip_select_low, 2) |-> !sda_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("drive while deselected");
  property p_take; $rose(sda_oe) |-> !scl_in && !chip_select_low; endproperty
  a_take: assert property (p_take) else $error("drive began in high phase");
  property p_free; $fell(sda_oe) |-> !scl_in || chip_select_low; endproperty
  a_free: assert property (p_free) else $error("drive ended in high phase");
  property p_hold; $rose(scl_in) |=> $stable(sda_oe) [*3]; endproperty
  a_hold: assert property (p_hold) else $error("data moved in high phase");
  property p_busy; $fell(converting) |-> run_len >= FAST_CYCLES; endproperty
  a_busy: assert property (p_busy) else $error("conversion too short");
  property p_go; $rose(converting) |-> !chip_select_low; endproperty
  a_go: assert property (p_go) else $error("start while deselected");
  property p_ctl; $changed({warming_element_on, measure_temp}) |-> !chip_select_low; endproperty
  a_ctl: assert property (p_ctl) else $error("control moved while deselected");
endmodule
bind sensor_i2c_register_port sensor_port_chk #(.FAST_CYCLES(FAST_CYCLES)) chk (
  .clock(clock), .nrst(nrst), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .chip_select_low(chip_select_low), .warming_element_on(warming_element_on),
  .measure_temp(measure_temp), .converting(converting));
`default_nettype wire

/* verif/bus_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  // clock
  input wire logic clock,
  // bus lines, data is open drain
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // two clocks per step keeps the bus period at eight clocks
  task automatic seq(input logic c, input logic d);
    repeat (2) @(posedge clock);
    scl <= c;
    sda_pull <= !d;
  endtask
  // data falls while clock high, also used as repeated start
  task automatic start;
    seq(1'b0, 1'b1);
    seq(1'b1, 1'b1);
    seq(1'b1, 1'b0);
    seq(1'b0, 1'b0);
  endtask
  task automatic stop;
    seq(1'b0, 1'b0);
    seq(1'b1, 1'b0);
    seq(1'b1, 1'b1);
  endtask
  // msb first plus ninth bit; sampled late in the high phase for margin
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      seq(1'b0, d[i]);
      seq(1'b1, d[i]);
      repeat (3) @(posedge clock);
      @(negedge clock) q[i] = sda;
      @(posedge clock) scl <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* verif/sensor_i2c_register_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sensor_i2c_register_port_tb;
  localparam int FAST = 60;
  localparam int NORM = 150;
  logic clock, nrst, chip_select_low, sda_oe, sda_out, scl, sda_pull;
  logic warming_element_on, measure_temp, converting;
  logic [15:0] sample_value, v;
  logic [8:0] q;
  logic [7:0] cfg [3] = '{8'h01, 8'h33, 8'h11};
  int miscompares, tests_run;
  wire sda = !sda_pull && (!sda_oe || sda_out); // pulled up when released
  // part code and revision values are arbitrary
  sensor_i2c_register_port #(.NORMAL_CYCLES(NORM), .FAST_CYCLES(FAST), .PART_CODE(8'h6c),
    .FW_MAJOR(4'h2), .FW_MINOR(4'h7)) dut (.clock(clock), .nrst(nrst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .chip_select_low(chip_select_low),
    .sample_value(sample_value), .warming_element_on(warming_element_on),
    .measure_temp(measure_temp), .converting(converting));
  bus_master_model m (.clock(clock), .scl(scl), .sda_pull(sda_pull), .sda(sda));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = !clock;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // send a byte, check the ninth bit (0 = taken)
  task automatic sb(input logic [7:0] d, input logic ack);
    m.xfer({d, 1'b1}, q);
    chk(q[0], ack);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    m.start();
    sb(8'h80, 1'b0);
    sb(p, 1'b0);
    sb(d, 1'b0);
    m.stop();
  endtask
  // one or two pointer bytes, repeated start, n bytes back
  task automatic rd(input logic [15:0] p, input logic two, input int n);
    m.start();
    sb(8'h80, 1'b0);
    if (two) sb(p[15:8], 1'b0);
    sb(p[7:0], 1'b0);
    m.start();
    sb(8'h81, 1'b0);
    v = 16'h0;
    for (int i = 1; i <= n; i++) begin
      m.xfer({8'hff, i == n}, q);
      v = {v[7:0], q[8:1]};
    end
    m.stop();
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog, far beyond the expected run
  initial begin
    #2000000;
    miscompares++;
    stop_test();
  end
  initial begin
    {nrst, chip_select_low, sample_value, miscompares, tests_run} = '0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(negedge clock);
    chk(converting, 1'b1);
    rd(16'h00, 1'b0, 1);
    chk(v, 16'h01);
    rd(16'h03, 1'b0, 1);
    chk(v, 16'h00);
    rd(16'h01, 1'b0, 2);
    chk(v, 16'h00);
    rd(16'h11, 1'b0, 1);
    chk(v, 16'h6c);
    rd(16'h84b8, 1'b1, 1);
    chk(v, 16'h27);
    foreach (cfg[k]) begin
      sample_value <= {cfg[k], ~cfg[k]};
      wr(8'h03, cfg[k]);
      repeat (FAST) @(negedge clock);
      chk(converting, !cfg[k][5]);
      chk({warming_element_on, measure_temp}, {cfg[k][1], cfg[k][4]});
      for (int n = 0; n < 200 && converting; n++) @(negedge clock);
      rd(16'h00, 1'b0, 1);
      chk(v, 16'h00);
      rd(16'h01, 1'b0, 2);
      chk(v, {cfg[k], ~cfg[k]});
    end
    wr(8'h03, 8'h22);
    rd(16'h03, 1'b0, 1);
    chk(v, 16'h22);
    wr(8'h00, 8'h01);
    rd(16'h00, 1'b0, 1);
    chk(v, 16'h00);
    m.start();
    sb(8'h82, 1'b1);
    m.stop();
    chip_select_low <= 1'b1;
    m.start();
    foreach (cfg[k]) sb(k == 0 ? 8'h80 : 8'h03 - k[7:0] + 8'h01, 1'b1);
    m.stop();
    chip_select_low <= 1'b0;
    rd(16'h03, 1'b0, 1);
    chk(v, 16'h22);
    stop_test();
  end
endmodule
`default_nettype wire
